/* core/scs_clk_switch.sv */
// Divider and switch that forms the system clock enable stream.
// Assumes source ticks are single-cycle pulses on sys_clk.
`timescale 1ns/1ps
module scs_clk_switch (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Sources
    input wire logic hs_tick,
    input wire logic hs_ok,
    input wire logic sub_tick,
    // Control
    input wire logic [2:0] sysclk_select,
    input wire logic run,
    // Output
    output logic sys_en,
    output logic [2:0] active_select
);
    logic [5:0] cnt_reg;
    logic base_tick;
    logic cur_ok;
    logic target_ok;

    function automatic logic [5:0] last_count(input logic [2:0] sel);
        if (sel == scs_pkg::SEL_SUB)
            return 6'h0;
        return 6'((7'h40 >> sel) - 7'h1);
    endfunction

    assign base_tick = (active_select == scs_pkg::SEL_SUB) ?
                       sub_tick : hs_tick;
    assign cur_ok = (active_select == scs_pkg::SEL_SUB) || hs_ok;
    assign target_ok = (sysclk_select == scs_pkg::SEL_SUB) || hs_ok;

    // New setting lands on a period boundary (at once if the current source is down and the new one is up), so no phase is cut short
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_reg <= '0;
            active_select <= scs_pkg::SEL_RESET;
            sys_en <= 1'b0;
        end else if (!cur_ok && target_ok) begin
            // Dead source gives no period to protect
            cnt_reg <= '0;
            active_select <= sysclk_select;
            sys_en <= 1'b0;
        end else if (run && base_tick) begin
            if (cnt_reg >= last_count(active_select)) begin
                cnt_reg <= '0;
                sys_en <= 1'b1;
                if (target_ok)
                    active_select <= sysclk_select;
            end else begin
                cnt_reg <= cnt_reg + 6'h1;
                sys_en <= 1'b0;
            end
        end else begin
            sys_en <= 1'b0;
        end
    end
endmodule

/* core/scs_pkg.sv */
// Constants shared by the system clock source select block.
// Assumes a 50 MHz sys_clk and a byte-wide register layout on Wishbone.
package scs_pkg;
    // Core clock rate, 50 MHz
    localparam logic [26:0] SYS_HZ = 27'h2FA_F080;
    // Internal RC tick steps in Hz: 1, 2, 4, 8, 12 MHz and 32 kHz
    localparam logic [26:0] RC_1M_STEP = 27'hF_4240;
    localparam logic [26:0] RC_2M_STEP = 27'h1E_8480;
    localparam logic [26:0] RC_4M_STEP = 27'h3D_0900;
    localparam logic [26:0] RC_8M_STEP = 27'h7A_1200;
    localparam logic [26:0] RC_12M_STEP = 27'hB7_1B00;
    localparam logic [26:0] LS_INTERNAL_RC_STEP = 27'h7D00;
    // Start-up waits, counted in cycles of the oscillator itself
    localparam logic [15:0] HS_INTERNAL_RC_START_TICKS = 16'h0010;
    localparam logic [15:0] HXT_START_TICKS = 16'h0400;
    localparam logic [15:0] LXT_START_TICKS = 16'h0400;
    // Register word offsets
    localparam logic [7:0] SYSCLK_CONTROL_OFS = 8'h00;
    localparam logic [7:0] RC_OSC_CONTROL_OFS = 8'h04;
    localparam logic [7:0] HS_XTAL_CONTROL_OFS = 8'h08;
    localparam logic [7:0] LS_XTAL_CONTROL_OFS = 8'h0C;
    localparam logic [7:0] MODE_STATUS_OFS = 8'h10;
    // Field positions in sysclk_control
    localparam int SEL_LSB = 5;
    localparam int HS_SRC_BIT = 3;
    localparam int LS_SRC_BIT = 2;
    localparam int HS_IDLE_BIT = 1;
    localparam int LS_IDLE_BIT = 0;
    // Field positions in the oscillator control words and the mode status word
    localparam int RC_MATCH_LSB = 2;
    localparam int OSC_READY_BIT = 1;
    localparam int OSC_ENABLE_BIT = 0;
    localparam int RC_MISMATCH_BIT = 4;
    // Values after reset
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] RC_MATCH_RESET = 3'h0;
    localparam logic RC_EN_RESET = 1'b1;
    localparam logic HXT_EN_RESET = 1'b0;
    localparam logic LXT_EN_RESET = 1'b0;
    // Select code that picks the low-speed clock
    localparam logic [2:0] SEL_SUB = 3'h7;

    typedef enum logic [2:0] {
        MODE_FAST = 3'b000,
        MODE_SLOW = 3'b001,
        MODE_IDLE0 = 3'b010,
        MODE_IDLE1 = 3'b011,
        MODE_IDLE2 = 3'b100,
        MODE_SLEEP = 3'b101
    } scs_mode_type;
endpackage

/* core/scs_sysclk_ctrl.sv */
// System clock source selection, oscillator control and mode decode.
// Assumes oscillator pads deliver square waves synchronous to sys_clk and
// a classic Wishbone master; all derived clocks are one-cycle enables.
`timescale 1ns/1ps

// Summary of operation
// - Two fast sources: external crystal and internal RC at 1-12 MHz.
// - Two slow sources: internal 32 kHz RC and 32.768 kHz crystal.
// - Three-bit select picks fast or slow system clock, changeable live.
// - One bit picks the slow oscillator, another the fast one.
// - Select field sets frequency: slow clock or divided fast clock.
// - Slow crystal runs at 32.768 kHz from its two pins.
// - Slow crystal clock also divided by eight for timers.
// - Slow crystal starts on enable, unusable until start-up wait ends.
// - Sleep or idle entry stops the processor clock.
// - A clock independent of the system clock keeps timers running.
// - Oscillators also clock the watchdog and time-base logic.
// - Fast mode divides the fast source by 1 to 64 per select.
// - With crystal enabled and started, crystal clocks calendar, time base, dog.
module scs_sysclk_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Oscillator pads
    input wire logic hs_crystal_pins,
    output logic hs_crystal_drive,
    input wire logic ls_crystal_pins,
    output logic ls_crystal_drive,
    // Configuration option and processor halt
    input wire logic [2:0] rc_freq_option,
    input wire logic cpu_halt,
    // Clock enables
    output logic cpu_clk_en,
    output logic sys_clk_en,
    output logic hs_clk_en,
    output logic sub_clk_en,
    output logic ls_crystal_clk,
    output logic timer_clk_en,
    output logic wdt_clk_en
);
    logic [2:0] sysclk_select_reg;
    logic hs_source_select_reg;
    logic ls_source_select_reg;
    logic hs_idle_on_reg;
    logic ls_idle_on_reg;
    logic [2:0] rc_freq_match_reg;
    logic rc_en_reg;
    logic hxt_en_reg;
    logic ls_crystal_enable_reg;
    logic [2:0] rc_option_reg;
    logic option_taken_reg;
    logic [15:0] rc_cnt_reg;
    logic [15:0] hxt_cnt_reg;
    logic [15:0] lxt_cnt_reg;
    logic hxt_pin_reg;
    logic lxt_pin_reg;
    logic [2:0] div8_reg;
    logic hs_internal_rc_tick;
    logic ls_internal_rc_tick;
    logic hxt_tick;
    logic lxt_tick;
    logic rc_ready;
    logic hxt_ready;
    logic lxt_ready;
    logic hs_run;
    logic sub_run;
    logic rc_run;
    logic ls_internal_rc_run;
    logic fh_tick;
    logic fsub_tick;
    logic hs_ok;
    logic sw_en;
    logic sleep_mode;
    logic req;
    logic wr;
    logic [2:0] active_select;
    scs_pkg::scs_mode_type mode;

    function automatic logic [26:0] rc_step(input logic [2:0] code);
        case (code)
            3'h1: return scs_pkg::RC_2M_STEP;
            3'h2: return scs_pkg::RC_4M_STEP;
            3'h3: return scs_pkg::RC_8M_STEP;
            3'h4: return scs_pkg::RC_12M_STEP;
            default: return scs_pkg::RC_1M_STEP;
        endcase
    endfunction

    function automatic logic [15:0] start_next(input logic [15:0] cnt,
                                               input logic [15:0] limit,
                                               input logic tick);
        if (tick && cnt < limit)
            return cnt + 16'h1;
        return cnt;
    endfunction

    // Bus slave: one wait state, every address answered
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge sys_clk) begin
        if (srst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sysclk_select_reg <= scs_pkg::SEL_RESET;
            hs_source_select_reg <= 1'b0;
            ls_source_select_reg <= 1'b0;
            hs_idle_on_reg <= 1'b0;
            ls_idle_on_reg <= 1'b0;
        end else if (wr && wb_adr_i == scs_pkg::SYSCLK_CONTROL_OFS) begin
            sysclk_select_reg <= wb_dat_i[scs_pkg::SEL_LSB +: 3];
            hs_source_select_reg <= wb_dat_i[scs_pkg::HS_SRC_BIT];
            ls_source_select_reg <= wb_dat_i[scs_pkg::LS_SRC_BIT];
            hs_idle_on_reg <= wb_dat_i[scs_pkg::HS_IDLE_BIT];
            ls_idle_on_reg <= wb_dat_i[scs_pkg::LS_IDLE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rc_freq_match_reg <= scs_pkg::RC_MATCH_RESET;
            rc_en_reg <= scs_pkg::RC_EN_RESET;
        end else if (wr && wb_adr_i == scs_pkg::RC_OSC_CONTROL_OFS) begin
            rc_freq_match_reg <= wb_dat_i[scs_pkg::RC_MATCH_LSB +: 3];
            rc_en_reg <= wb_dat_i[scs_pkg::OSC_ENABLE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hxt_en_reg <= scs_pkg::HXT_EN_RESET;
            ls_crystal_enable_reg <= scs_pkg::LXT_EN_RESET;
        end else if (wr) begin
            if (wb_adr_i == scs_pkg::HS_XTAL_CONTROL_OFS)
                hxt_en_reg <= wb_dat_i[scs_pkg::OSC_ENABLE_BIT];
            if (wb_adr_i == scs_pkg::LS_XTAL_CONTROL_OFS)
                ls_crystal_enable_reg <=
                    wb_dat_i[scs_pkg::OSC_ENABLE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_dat_o <= '0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= '0;
            unique case (wb_adr_i)
                scs_pkg::SYSCLK_CONTROL_OFS: begin
                    wb_dat_o[scs_pkg::SEL_LSB +: 3] <= sysclk_select_reg;
                    wb_dat_o[scs_pkg::HS_SRC_BIT] <= hs_source_select_reg;
                    wb_dat_o[scs_pkg::LS_SRC_BIT] <= ls_source_select_reg;
                    wb_dat_o[scs_pkg::HS_IDLE_BIT] <= hs_idle_on_reg;
                    wb_dat_o[scs_pkg::LS_IDLE_BIT] <= ls_idle_on_reg;
                end
                scs_pkg::RC_OSC_CONTROL_OFS: begin
                    wb_dat_o[scs_pkg::RC_MATCH_LSB +: 3] <= rc_freq_match_reg;
                    wb_dat_o[scs_pkg::OSC_READY_BIT] <= rc_ready;
                    wb_dat_o[scs_pkg::OSC_ENABLE_BIT] <= rc_en_reg;
                end
                scs_pkg::HS_XTAL_CONTROL_OFS: begin
                    wb_dat_o[scs_pkg::OSC_READY_BIT] <= hxt_ready;
                    wb_dat_o[scs_pkg::OSC_ENABLE_BIT] <= hxt_en_reg;
                end
                scs_pkg::LS_XTAL_CONTROL_OFS: begin
                    wb_dat_o[scs_pkg::OSC_READY_BIT] <= lxt_ready;
                    wb_dat_o[scs_pkg::OSC_ENABLE_BIT] <=
                        ls_crystal_enable_reg;
                end
                scs_pkg::MODE_STATUS_OFS: begin
                    wb_dat_o[2:0] <= mode;
                    wb_dat_o[scs_pkg::RC_MISMATCH_BIT] <=
                        (rc_freq_match_reg != rc_option_reg);
                    wb_dat_o[scs_pkg::SEL_LSB +: 3] <= active_select;
                end
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // Option strap is caught once, after reset release
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            option_taken_reg <= 1'b0;
            rc_option_reg <= '0;
        end else if (!option_taken_reg) begin
            option_taken_reg <= 1'b1;
            rc_option_reg <= rc_freq_option;
        end
    end

    // Operating mode from halt and the two idle keep-alive bits
    always_comb begin
        if (!cpu_halt)
            mode = (sysclk_select_reg == scs_pkg::SEL_SUB) ?
                   scs_pkg::MODE_SLOW : scs_pkg::MODE_FAST;
        else begin
            unique case ({hs_idle_on_reg, ls_idle_on_reg})
                2'b00: mode = scs_pkg::MODE_SLEEP;
                2'b01: mode = scs_pkg::MODE_IDLE0;
                2'b11: mode = scs_pkg::MODE_IDLE1;
                2'b10: mode = scs_pkg::MODE_IDLE2;
            endcase
        end
    end

    assign sleep_mode = (mode == scs_pkg::MODE_SLEEP);
    assign hs_run = !cpu_halt || hs_idle_on_reg;
    assign sub_run = !cpu_halt || ls_idle_on_reg;
    // Selected RC is kept alive in fast mode even with its enable low
    assign rc_run = hs_run && (rc_en_reg || (!hs_source_select_reg &&
                    mode == scs_pkg::MODE_FAST));
    assign ls_internal_rc_run = !sleep_mode;

    // Internal oscillators
    scs_tick_gen u_hs_internal_rc (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(rc_run),
        .step(rc_step(rc_option_reg)),
        .tick(hs_internal_rc_tick)
    );

    scs_tick_gen u_ls_internal_rc (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(ls_internal_rc_run),
        .step(scs_pkg::LS_INTERNAL_RC_STEP),
        .tick(ls_internal_rc_tick)
    );

    // Crystal pads: rising edges of the oscillator wave are ticks
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hxt_pin_reg <= 1'b0;
            lxt_pin_reg <= 1'b0;
        end else begin
            hxt_pin_reg <= hs_crystal_pins;
            lxt_pin_reg <= ls_crystal_pins;
        end
    end

    assign hxt_tick = hxt_en_reg && hs_run &&
                      hs_crystal_pins && !hxt_pin_reg;
    assign lxt_tick = ls_crystal_enable_reg &&
                      ls_crystal_pins && !lxt_pin_reg;
    assign hs_crystal_drive = hxt_en_reg;
    assign ls_crystal_drive = ls_crystal_enable_reg;

    // Start-up waits; a dropped enable restarts the wait
    always_ff @(posedge sys_clk) begin
        if (srst || !rc_run)
            rc_cnt_reg <= '0;
        else
            rc_cnt_reg <= start_next(rc_cnt_reg,
                                     scs_pkg::HS_INTERNAL_RC_START_TICKS, hs_internal_rc_tick);
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !hxt_en_reg)
            hxt_cnt_reg <= '0;
        else
            hxt_cnt_reg <= start_next(hxt_cnt_reg,
                                      scs_pkg::HXT_START_TICKS, hxt_tick);
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !ls_crystal_enable_reg)
            lxt_cnt_reg <= '0;
        else
            lxt_cnt_reg <= start_next(lxt_cnt_reg,
                                      scs_pkg::LXT_START_TICKS,
                                      lxt_tick);
    end

    assign rc_ready = (rc_cnt_reg == scs_pkg::HS_INTERNAL_RC_START_TICKS);
    assign hxt_ready = (hxt_cnt_reg == scs_pkg::HXT_START_TICKS);
    assign lxt_ready = (lxt_cnt_reg == scs_pkg::LXT_START_TICKS);

    // Fast and slow clocks from the chosen oscillators
    assign hs_ok = hs_source_select_reg ? hxt_ready : rc_ready;
    assign fh_tick = hs_run && (hs_source_select_reg ?
                     (hxt_tick && hxt_ready) :
                     (hs_internal_rc_tick && rc_ready));
    // Crystal picked but not started: slow clock falls back to the RC
    assign fsub_tick = sub_run && ((ls_source_select_reg && lxt_ready) ?
                       lxt_tick : ls_internal_rc_tick);

    scs_clk_switch u_switch (
        .sys_clk(sys_clk),
        .srst(srst),
        .hs_tick(fh_tick),
        .hs_ok(hs_ok),
        .sub_tick(fsub_tick),
        .sysclk_select(sysclk_select_reg),
        .run(!sleep_mode),
        .sys_en(sw_en),
        .active_select(active_select)
    );

    assign sys_clk_en = sw_en;
    assign cpu_clk_en = sw_en && !cpu_halt;
    assign hs_clk_en = fh_tick;
    assign sub_clk_en = fsub_tick;
    assign ls_crystal_clk = lxt_tick && lxt_ready;

    // Divide-by-eight runs regardless of halt or sleep
    always_ff @(posedge sys_clk) begin
        if (srst || !lxt_ready)
            div8_reg <= '0;
        else if (lxt_tick)
            div8_reg <= div8_reg + 3'h1;
    end

    assign timer_clk_en = lxt_tick && lxt_ready &&
                          div8_reg == 3'h7;
    // Watchdog falls back to the slow RC while the crystal is not up
    assign wdt_clk_en = lxt_ready ? timer_clk_en : ls_internal_rc_tick;
endmodule

/* core/scs_tick_gen.sv */
// Fractional tick generator standing in for an on-chip RC oscillator.
// Assumes step is below the core rate; one tick per SYS_HZ/step cycles.
`timescale 1ns/1ps
module scs_tick_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Control
    input wire logic enable,
    input wire logic [26:0] step,
    // Output pulse
    output logic tick
);
    logic [26:0] acc_reg;
    logic [27:0] sum;

    assign sum = {1'b0, acc_reg} + {1'b0, step};

    always_ff @(posedge sys_clk) begin
        if (srst || !enable) begin
            acc_reg <= '0;
            tick <= 1'b0;
        end else if (sum >= {1'b0, scs_pkg::SYS_HZ}) begin
            acc_reg <= 27'(sum - {1'b0, scs_pkg::SYS_HZ});
            tick <= 1'b1;
        end else begin
            acc_reg <= sum[26:0];
            tick <= 1'b0;
        end
    end
endmodule

/* dv/scs_sysclk_checker.sv */
// Port-level assertions for the system clock select block.
// Sees only the top module's ports; bound from the bench top.
`timescale 1ns/1ps
module scs_sysclk_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Pads, halt and enables
    input wire logic hs_crystal_drive,
    input wire logic ls_crystal_drive,
    input wire logic cpu_halt,
    input wire logic cpu_clk_en,
    input wire logic sys_clk_en,
    input wire logic ls_crystal_clk,
    input wire logic timer_clk_en
);
    logic [2:0] ls_cnt_reg;

    // Phase of the /8 divider, restarted while the crystal is off
    always_ff @(posedge sys_clk) begin
        if (srst || !ls_crystal_drive) begin
            ls_cnt_reg <= 3'h0;
        end else if (ls_crystal_clk) begin
            ls_cnt_reg <= ls_cnt_reg + 3'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not acked next cycle");
    cpu_gate_a: assert property (cpu_halt |-> !cpu_clk_en)
        else $error("cpu clock while halted");
    cpu_in_sys_a: assert property (cpu_clk_en |-> sys_clk_en)
        else $error("cpu clock without system clock");
    sys_pulse_a: assert property (sys_clk_en |=> !sys_clk_en)
        else $error("system clock phase shortened");
    ls_start_a: assert property ($rose(ls_crystal_drive)
        |=> !ls_crystal_clk [*8]) else $error("crystal clock before start");
    timer_sub_a: assert property (timer_clk_en |-> ls_crystal_clk)
        else $error("timer pulse off crystal edge");
    timer_div_a: assert property (ls_crystal_clk
        |-> timer_clk_en == (ls_cnt_reg == 3'h7))
        else $error("timer pulse not every eighth");
    reset_quiet_a: assert property ($fell(srst) |-> !wb_ack_o
        && !sys_clk_en && !hs_crystal_drive && !ls_crystal_drive)
        else $error("outputs active after reset");
endmodule

/* dv/scs_xtal_model.sv */
// Behavioural crystal: square wave on the pad while its amplifier runs.
// Assumes pads are sampled on sys_clk; half period in sys_clk cycles.
`timescale 1ns/1ps
module scs_xtal_model #(
    parameter int HALF = 1
) (
    input wire logic sys_clk,
    input wire logic drive,
    output logic pin
);
    int cnt = 0;

    initial begin
        pin = 1'b0;
    end

    // A crystal without its amplifier gives no edges at all
    always @(posedge sys_clk) begin
        if (!drive) begin
            pin <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            pin <= !pin;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* dv/test_system_clock_source_select.sv */
// Self-checking bench for the system clock select block.
// Crystals are modelled fast; pad periods 2 and 4 sys_clk cycles.
`timescale 1ns/1ps
module test_system_clock_source_select;
    logic sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic hs_crystal_pins, hs_crystal_drive, cpu_halt;
    logic ls_crystal_pins, ls_crystal_drive;
    logic [2:0] rc_freq_option;
    logic cpu_clk_en, sys_clk_en, hs_clk_en, sub_clk_en;
    logic ls_crystal_clk, timer_clk_en, wdt_clk_en;
    int failures = 0;
    int checks_done = 0;
    int g, n_sys, n_cpu, n_tim, n_ls, n_wdt, n_hs, n_sub;

    scs_sysclk_ctrl u_scs_sysclk_ctrl (.sys_clk, .srst, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .hs_crystal_pins, .hs_crystal_drive, .ls_crystal_pins,
        .ls_crystal_drive, .rc_freq_option, .cpu_halt, .cpu_clk_en,
        .sys_clk_en, .hs_clk_en, .sub_clk_en, .ls_crystal_clk,
        .timer_clk_en, .wdt_clk_en);
    scs_xtal_model #(.HALF(1)) u_scs_xtal_model (.sys_clk,
        .drive(hs_crystal_drive), .pin(hs_crystal_pins));
    scs_xtal_model #(.HALF(2)) u_scs_xtal_model_ls (.sys_clk,
        .drive(ls_crystal_drive), .pin(ls_crystal_pins));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_val(input string name, input logic [31:0] exp,
                             input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // Registered ack: taken at the first edge, seen at the second
        check_val("ack wait", 32'h2, 32'(n));
    endtask

    task automatic wait_en(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (sys_clk_en !== 1'b1 && n < 4000);
    endtask

    // Skips the switch-over period before measuring one full period
    task automatic gap();
        wait_en(g);
        wait_en(g);
        wait_en(g);
    endtask

    task automatic count_win();
        {n_sys, n_cpu, n_tim, n_ls, n_wdt, n_hs, n_sub} = '0;
        repeat (256) begin
            @(posedge sys_clk);
            n_sys += int'(sys_clk_en === 1'b1);
            n_cpu += int'(cpu_clk_en === 1'b1);
            n_tim += int'(timer_clk_en === 1'b1);
            n_ls += int'(ls_crystal_clk === 1'b1);
            n_wdt += int'(wdt_clk_en === 1'b1);
            n_hs += int'(hs_clk_en === 1'b1);
            n_sub += int'(sub_clk_en === 1'b1);
        end
    endtask

    task automatic wait_ready(input logic [7:0] adr);
        for (int i = 0; i < 60; i++) begin
            wb_cycle(1'b0, adr, 32'h0);
            if (rd[1] === 1'b1) break;
            repeat (100) @(posedge sys_clk);
        end
        check_val("ready", 32'h1, {31'h0, rd[1]});
    endtask

    task automatic t_reset();
        wb_cycle(1'b0, scs_pkg::SYSCLK_CONTROL_OFS, 32'h0);
        check_val("sysclk_control", 32'h0, rd);
        wb_cycle(1'b0, scs_pkg::RC_OSC_CONTROL_OFS, 32'h0);
        check_val("rc_osc_control", 32'h1, rd & 32'h1D);
        wb_cycle(1'b0, scs_pkg::LS_XTAL_CONTROL_OFS, 32'h0);
        check_val("ls enable", 32'h0, rd & 32'h1);
        wb_cycle(1'b1, 8'h20, 32'hFF);
        wb_cycle(1'b0, 8'h20, 32'h0);
        check_val("unmapped", 32'h0, rd);
        wb_cycle(1'b0, scs_pkg::MODE_STATUS_OFS, 32'h0);
        check_val("mode", 32'(scs_pkg::MODE_FAST), rd & 32'h7);
        $display("test reset done");
    endtask

    task automatic t_mismatch();
        wb_cycle(1'b1, scs_pkg::RC_OSC_CONTROL_OFS, 32'h9);
        wb_cycle(1'b0, scs_pkg::MODE_STATUS_OFS, 32'h0);
        check_val("rc match flag", 32'h0, {31'h0, rd[4]});
        wb_cycle(1'b1, scs_pkg::RC_OSC_CONTROL_OFS, 32'hD);
        wb_cycle(1'b0, scs_pkg::MODE_STATUS_OFS, 32'h0);
        check_val("rc match flag", 32'h1, {31'h0, rd[4]});
        $display("test rc match done");
    endtask

    task automatic t_ratio();
        wb_cycle(1'b1, scs_pkg::HS_XTAL_CONTROL_OFS, 32'h1);
        check_val("hs drive", 32'h1, {31'h0, hs_crystal_drive});
        wait_ready(scs_pkg::HS_XTAL_CONTROL_OFS);
        for (int c = 0; c < 7; c++) begin
            wb_cycle(1'b1, scs_pkg::SYSCLK_CONTROL_OFS, 32'(c << 5) | 32'h8);
            gap();
            check_val("fast gap", 32'(2 * (64 >> c)), 32'(g));
            wb_cycle(1'b0, scs_pkg::MODE_STATUS_OFS, 32'h0);
            check_val("active select", 32'(c), 32'(rd[7:5]));
        end
        $display("test ratio done");
    endtask

    task automatic t_slow();
        wb_cycle(1'b1, scs_pkg::SYSCLK_CONTROL_OFS, 32'hE0);
        gap();
        check_val("rc slow", 32'h1, 32'(g == 1562 || g == 1563));
        wb_cycle(1'b1, scs_pkg::SYSCLK_CONTROL_OFS, 32'hE4);
        gap();
        check_val("fallback", 32'h1, 32'(g == 1562 || g == 1563));
        wb_cycle(1'b1, scs_pkg::LS_XTAL_CONTROL_OFS, 32'h1);
        count_win();
        check_val("early crystal", 32'h0, 32'(n_ls));
        wait_ready(scs_pkg::LS_XTAL_CONTROL_OFS);
        gap();
        check_val("crystal slow", 32'h4, 32'(g));
        $display("test slow done");
    endtask

    task automatic t_timer();
        count_win();
        check_val("crystal pulses", 32'd64, 32'(n_ls));
        check_val("timer pulses", 32'h8, 32'(n_tim));
        check_val("watchdog pulses", 32'h8, 32'(n_wdt));
        check_val("slow pulses", 32'd64, 32'(n_sub));
        // 4 MHz RC against 50 MHz: 20.48 ticks per window
        check_val("fast pulses", 32'h1, 32'(n_hs == 20 || n_hs == 21));
        $display("test timer done");
    endtask

    task automatic t_halt();
        @(posedge sys_clk);
        cpu_halt <= 1'b1;
        wb_cycle(1'b0, scs_pkg::MODE_STATUS_OFS, 32'h0);
        check_val("sleep", 32'(scs_pkg::MODE_SLEEP), rd & 32'h7);
        count_win();
        check_val("sleep sys", 32'h0, 32'(n_sys + n_cpu));
        check_val("sleep timer", 32'h8, 32'(n_tim));
        check_val("sleep clocks", 32'h0, 32'(n_hs + n_sub));
        wb_cycle(1'b1, scs_pkg::SYSCLK_CONTROL_OFS, 32'hE5);
        count_win();
        check_val("idle sys", 32'd64, 32'(n_sys));
        check_val("idle cpu", 32'h0, 32'(n_cpu));
        check_val("idle0 fast", 32'h0, 32'(n_hs));
        @(posedge sys_clk);
        cpu_halt <= 1'b0;
        wb_cycle(1'b0, scs_pkg::MODE_STATUS_OFS, 32'h0);
        check_val("slow", 32'(scs_pkg::MODE_SLOW), rd & 32'h7);
        count_win();
        check_val("slow cpu", 32'd64, 32'(n_cpu));
        $display("test halt done");
    endtask

    initial begin
        // Tests need about 16k cycles; generous margin, still bounded
        #(20 * 60000);
        failures++;
        $display("wrong value run expected done seen hang");
        finish_test();
    end

    initial begin
        srst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, cpu_halt} = 4'h0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0;
        rc_freq_option = 3'h2;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_mismatch();
        t_ratio();
        t_slow();
        t_timer();
        t_halt();
        finish_test();
    end
endmodule

bind scs_sysclk_ctrl scs_sysclk_checker u_scs_sysclk_checker (.sys_clk,
    .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .hs_crystal_drive,
    .ls_crystal_drive, .cpu_halt, .cpu_clk_en, .sys_clk_en,
    .ls_crystal_clk, .timer_clk_en);
